// ==== dpsm_pkg.sv ====
// package for the drive power state machine: register map, codes, timing
// assumes a 100 MHz system clock and a plain single-cycle register port
package dpsm_pkg;

    // ----------------------------------------------------------------
    // register map (word offsets on the plain register port)
    // ----------------------------------------------------------------
    localparam logic [3:0] DPSM_OFF_CTRL = 4'h0; // control word
    localparam logic [3:0] DPSM_OFF_STAT = 4'h1; // status word
    localparam logic [3:0] DPSM_OFF_QSMODE = 4'h2; // quick-stop mode
    localparam logic [3:0] DPSM_OFF_PARAM = 4'h3; // ordinary parameter
    localparam logic [3:0] DPSM_OFF_RPARAM = 4'h4; // restricted parameter
    localparam logic [3:0] DPSM_OFF_WREJ = 4'h5; // rejected-write counter

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] DPSM_RST_CTRL = 16'h0006;
    localparam logic [7:0] DPSM_RST_QSMODE = 8'h02;
    localparam logic [15:0] DPSM_RST_PARAM = 16'h0000;

    // ----------------------------------------------------------------
    // control values judged on bits 3..0, and the fault reset value
    // ----------------------------------------------------------------
    localparam logic [3:0] DPSM_CW_DISABLE = 4'h0;
    localparam logic [3:0] DPSM_CW_QSTOP = 4'h2;
    localparam logic [3:0] DPSM_CW_SHUTDOWN = 4'h6;
    localparam logic [3:0] DPSM_CW_SWITCHON = 4'h7;
    localparam logic [3:0] DPSM_CW_ENABLE = 4'hF;
    localparam logic [7:0] DPSM_CW_FRESET = 8'h86;

    // ----------------------------------------------------------------
    // status word values
    // ----------------------------------------------------------------
    localparam logic [15:0] DPSM_SW_INIT = 16'h0000;
    localparam logic [15:0] DPSM_SW_DISABLED = 16'h0070;
    localparam logic [15:0] DPSM_SW_DIS_FRST = 16'h0031; // after fault reset
    localparam logic [15:0] DPSM_SW_READY = 16'h0031;
    localparam logic [15:0] DPSM_SW_SWON = 16'h0033;
    localparam logic [15:0] DPSM_SW_OPEN = 16'h0037;
    localparam logic [15:0] DPSM_SW_QSTOP = 16'h0050;
    localparam logic [15:0] DPSM_SW_FREACT = 16'h0038;
    localparam logic [15:0] DPSM_SW_FAULT = 16'h0038;

    // ----------------------------------------------------------------
    // quick-stop modes
    // ----------------------------------------------------------------
    localparam logic [7:0] DPSM_QS_M0 = 8'h00;
    localparam logic [7:0] DPSM_QS_M1 = 8'h01;
    localparam logic [7:0] DPSM_QS_M2 = 8'h02;
    localparam logic [7:0] DPSM_QS_M5 = 8'h05;
    localparam logic [7:0] DPSM_QS_M6 = 8'h06;
    localparam logic [7:0] DPSM_QS_M18 = 8'h12;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int DPSM_CLK_MHZ = 100;
    localparam int DPSM_INIT_NS = 1000; // self-initialisation time
    localparam int DPSM_INIT_CYC = (DPSM_INIT_NS * DPSM_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] DPSM_INIT_CNT = 8'(DPSM_INIT_CYC);

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DPSM_ST_INIT,
        DPSM_ST_DISABLED,
        DPSM_ST_READY,
        DPSM_ST_SWON,
        DPSM_ST_OPEN,
        DPSM_ST_QSTOP,
        DPSM_ST_FREACT,
        DPSM_ST_FAULT
    } dpsm_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } dpsm_req_t;

    typedef struct packed {
        logic power_on;  // main power stage energised
        logic drive_en;  // drive function / motor running
        logic qs_decel;  // quick-stop deceleration active
        logic err_decel; // error-stop deceleration active
    } dpsm_pwr_t;

endpackage

// ==== dpsm_top.sv ====
// drive power state machine: control word in, status word and power out
// assumes fault, stop-done and io reset pins are asynchronous to clk;
// the register port is synchronous to clk.
//
// Overview of operation
// - enter initialisation alone after power-up
// - initialisation done, go to switch-on-disabled
// - disabled plus control 6 gives ready, 31
// - ready plus control 7 gives switched-on, 33
// - switched-on plus F gives operation, 0037
// - operation plus 7 gives switched-on, 0033
// - switched-on plus 6 gives ready, 0031
// - ready plus 0 gives disabled, 0070
// - operation plus 6 gives ready, 0031
// - operation plus 0 gives disabled, 0070
// - operation plus 2 gives quick-stop, 0050
// - stop done, modes 0,1,2,18: disabled
// - quick-stop, modes 5/6, F: operation
// - fault forces fault-reaction from any state but fault-reaction and fault
// - fault-reaction stops motor, then fault, 0038
// - fault plus 86 or io reset: disabled
// - reject parameter writes during initialisation
// - allow parameter writes in ready, switched-on
// - block restricted parameters while operating
// - quick-stop decelerates alike in every quick-stop mode; the mode picks the exit
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

module dpsm_top
    import dpsm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire dpsm_req_t req,
    output logic [15:0] rdata,
    input wire logic fault_in,
    input wire logic stop_done_in,
    input wire logic io_freset_in,
    output dpsm_pwr_t pwr,
    output logic [15:0] status_word
);

    // ----------------------------------------------------------------
    // state and registers
    // ----------------------------------------------------------------
    dpsm_state_t state_q;
    logic [15:0] ctrl_q;
    logic [15:0] stat_q;
    logic [7:0] qsmode_q;
    logic [15:0] param_q;
    logic [15:0] rparam_q;
    logic [15:0] wrej_q;
    logic [7:0] init_cnt_q;
    logic cw_new_q;
    logic [2:0] fault_s;
    logic [2:0] done_s;
    logic [2:0] frst_s;
    logic fault_q;
    logic done_q;
    logic frst_q;
    logic frst_dis_q;

    // quick-stop modes that end in switch-on-disabled
    function automatic logic qs_ends_disabled(input logic [7:0] m);
        return (m == DPSM_QS_M0) || (m == DPSM_QS_M1) ||
               (m == DPSM_QS_M2) || (m == DPSM_QS_M18);
    endfunction

    // quick-stop modes that allow re-enabling
    function automatic logic qs_may_resume(input logic [7:0] m);
        return (m == DPSM_QS_M5) || (m == DPSM_QS_M6);
    endfunction

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // three flops per pin, the second feeds the logic; the io reset edge also uses the third
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_s <= 3'h0;
            done_s <= 3'h0;
            frst_s <= 3'h0;
        end else begin
            fault_s <= {fault_s[1:0], fault_in};
            done_s <= {done_s[1:0], stop_done_in};
            frst_s <= {frst_s[1:0], io_freset_in};
        end
    end

    always_comb begin
        fault_q = fault_s[1];
        done_q = done_s[1];
        frst_q = frst_s[1] & ~frst_s[2]; // rising edge of io reset
    end

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    logic wr_ctrl;
    logic wr_qs;
    logic wr_par;
    logic wr_rpar;
    logic par_ok;
    logic rpar_ok;

    always_comb begin
        wr_ctrl = req.wr && (req.addr == DPSM_OFF_CTRL);
        wr_qs = req.wr && (req.addr == DPSM_OFF_QSMODE);
        wr_par = req.wr && (req.addr == DPSM_OFF_PARAM);
        wr_rpar = req.wr && (req.addr == DPSM_OFF_RPARAM);
        par_ok = (state_q != DPSM_ST_INIT);
        rpar_ok = par_ok && (state_q != DPSM_ST_OPEN) &&
                  (state_q != DPSM_ST_QSTOP);
    end

    // control word register, new-value flag for one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= DPSM_RST_CTRL;
            cw_new_q <= 1'b0;
        end else begin
            cw_new_q <= wr_ctrl;
            if (wr_ctrl) begin
                ctrl_q <= req.wdata;
            end
        end
    end

    // parameter registers with state-dependent write protection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qsmode_q <= DPSM_RST_QSMODE;
            param_q <= DPSM_RST_PARAM;
            rparam_q <= DPSM_RST_PARAM;
            wrej_q <= 16'h0000;
        end else begin
            if (wr_qs && rpar_ok) begin
                qsmode_q <= req.wdata[7:0];
            end
            if (wr_par && par_ok) begin
                param_q <= req.wdata;
            end
            if (wr_rpar && rpar_ok) begin
                rparam_q <= req.wdata;
            end
            if (((wr_par) && !par_ok) || ((wr_rpar || wr_qs) && !rpar_ok)) begin
                wrej_q <= wrej_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    logic [3:0] cw;
    assign cw = ctrl_q[3:0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= DPSM_ST_INIT;
            init_cnt_q <= 8'h00;
            frst_dis_q <= 1'b0;
        end else begin
            if (state_q == DPSM_ST_INIT && init_cnt_q != DPSM_INIT_CNT) begin
                init_cnt_q <= init_cnt_q + 8'h01;
            end
            if (fault_q && state_q != DPSM_ST_FREACT && state_q != DPSM_ST_FAULT) begin
                state_q <= DPSM_ST_FREACT;
                frst_dis_q <= 1'b0;
            end else begin
                case (state_q)
                    DPSM_ST_INIT: begin
                        if (init_cnt_q == DPSM_INIT_CNT) begin
                            state_q <= DPSM_ST_DISABLED;
                        end
                    end
                    DPSM_ST_DISABLED: begin
                        if (cw_new_q && cw == DPSM_CW_SHUTDOWN) begin
                            state_q <= DPSM_ST_READY;
                            frst_dis_q <= 1'b0;
                        end
                    end
                    DPSM_ST_READY: begin
                        if (cw_new_q && cw == DPSM_CW_SWITCHON) begin
                            state_q <= DPSM_ST_SWON;
                        end else if (cw_new_q && cw == DPSM_CW_DISABLE) begin
                            state_q <= DPSM_ST_DISABLED;
                        end
                    end
                    DPSM_ST_SWON: begin
                        if (cw_new_q && cw == DPSM_CW_ENABLE) begin
                            state_q <= DPSM_ST_OPEN;
                        end else if (cw_new_q && cw == DPSM_CW_SHUTDOWN) begin
                            state_q <= DPSM_ST_READY;
                        end
                    end
                    DPSM_ST_OPEN: begin
                        if (cw_new_q && cw == DPSM_CW_SWITCHON) begin
                            state_q <= DPSM_ST_SWON;
                        end else if (cw_new_q && cw == DPSM_CW_SHUTDOWN) begin
                            state_q <= DPSM_ST_READY;
                        end else if (cw_new_q && cw == DPSM_CW_DISABLE) begin
                            state_q <= DPSM_ST_DISABLED;
                        end else if (cw_new_q && cw == DPSM_CW_QSTOP) begin
                            state_q <= DPSM_ST_QSTOP;
                        end
                    end
                    DPSM_ST_QSTOP: begin
                        if (cw_new_q && cw == DPSM_CW_ENABLE && qs_may_resume(qsmode_q)) begin
                            state_q <= DPSM_ST_OPEN;
                        end else if (done_q && qs_ends_disabled(qsmode_q)) begin
                            state_q <= DPSM_ST_DISABLED;
                        end
                    end
                    DPSM_ST_FREACT: begin
                        if (done_q) begin
                            state_q <= DPSM_ST_FAULT;
                        end
                    end
                    DPSM_ST_FAULT: begin
                        if ((cw_new_q && ctrl_q[7:0] == DPSM_CW_FRESET) || frst_q) begin
                            state_q <= DPSM_ST_DISABLED;
                            frst_dis_q <= 1'b1;
                        end
                    end
                    default: begin
                        state_q <= DPSM_ST_INIT;
                    end
                endcase
                // any other control value leaves the state alone
            end
        end
    end

    // ----------------------------------------------------------------
    // status word and power outputs, registered from the state
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_q <= DPSM_SW_INIT;
            pwr <= '0;
        end else begin
            case (state_q)
                DPSM_ST_INIT: begin
                    stat_q <= DPSM_SW_INIT;
                    pwr <= '0;
                end
                DPSM_ST_DISABLED: begin
                    stat_q <= frst_dis_q ? DPSM_SW_DIS_FRST : DPSM_SW_DISABLED;
                    pwr <= '0;
                end
                DPSM_ST_READY: begin
                    stat_q <= DPSM_SW_READY;
                    pwr <= '0;
                end
                DPSM_ST_SWON: begin
                    stat_q <= DPSM_SW_SWON;
                    pwr <= '{power_on: 1'b1, drive_en: 1'b0, qs_decel: 1'b0, err_decel: 1'b0};
                end
                DPSM_ST_OPEN: begin
                    stat_q <= DPSM_SW_OPEN;
                    pwr <= '{power_on: 1'b1, drive_en: 1'b1, qs_decel: 1'b0, err_decel: 1'b0};
                end
                DPSM_ST_QSTOP: begin
                    stat_q <= DPSM_SW_QSTOP;
                    pwr <= '{power_on: 1'b1, drive_en: 1'b1, qs_decel: 1'b1, err_decel: 1'b0};
                end
                DPSM_ST_FREACT: begin
                    stat_q <= DPSM_SW_FREACT;
                    pwr <= '{power_on: 1'b1, drive_en: 1'b1, qs_decel: 1'b0, err_decel: 1'b1};
                end
                DPSM_ST_FAULT: begin
                    stat_q <= DPSM_SW_FAULT;
                    pwr <= '0;
                end
                default: begin
                    stat_q <= DPSM_SW_INIT;
                    pwr <= '0;
                end
            endcase
        end
    end

    assign status_word = stat_q;

    // ----------------------------------------------------------------
    // read port: data in the cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (req.rd) begin
            case (req.addr)
                DPSM_OFF_CTRL: rdata <= ctrl_q;
                DPSM_OFF_STAT: rdata <= stat_q;
                DPSM_OFF_QSMODE: rdata <= {8'h00, qsmode_q};
                DPSM_OFF_PARAM: rdata <= param_q;
                DPSM_OFF_RPARAM: rdata <= rparam_q;
                DPSM_OFF_WREJ: rdata <= wrej_q;
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_cw(logic [3:0] v);
        cw_new_q && cw == v;
    endsequence

    property p_init_leave;
        @(posedge clk) disable iff (rst)
        (state_q == DPSM_ST_INIT && !fault_q && init_cnt_q == DPSM_INIT_CNT)
            |=> state_q == DPSM_ST_DISABLED;
    endproperty
    a_init_leave: assert property (p_init_leave) else $error("init did not end");

    property p_ready;
        @(posedge clk) disable iff (rst)
        (state_q == DPSM_ST_DISABLED && !fault_q) ##0 s_cw(DPSM_CW_SHUTDOWN)
            |=> state_q == DPSM_ST_READY ##1 stat_q == DPSM_SW_READY;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not reached");

    property p_swon;
        @(posedge clk) disable iff (rst)
        (state_q == DPSM_ST_READY && !fault_q) ##0 s_cw(DPSM_CW_SWITCHON)
            |=> ##1 stat_q == DPSM_SW_SWON;
    endproperty
    a_swon: assert property (p_swon) else $error("switched-on not reported");

    property p_open;
        @(posedge clk) disable iff (rst)
        (state_q == DPSM_ST_SWON && !fault_q) ##0 s_cw(DPSM_CW_ENABLE)
            |=> ##1 (stat_q == DPSM_SW_OPEN && pwr.drive_en);
    endproperty
    a_open: assert property (p_open) else $error("operation not enabled");

    property p_qstop;
        @(posedge clk) disable iff (rst)
        (state_q == DPSM_ST_OPEN && !fault_q) ##0 s_cw(DPSM_CW_QSTOP)
            |=> ##1 stat_q == DPSM_SW_QSTOP;
    endproperty
    a_qstop: assert property (p_qstop) else $error("quick stop not entered");

    property p_fault;
        @(posedge clk) disable iff (rst)
        (fault_q && state_q != DPSM_ST_FREACT && state_q != DPSM_ST_FAULT)
            |=> state_q == DPSM_ST_FREACT;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not taken");

    property p_fault_stat;
        @(posedge clk) disable iff (rst)
        (state_q == DPSM_ST_FAULT) |=> (stat_q == DPSM_SW_FAULT && !pwr.power_on);
    endproperty
    a_fault_stat: assert property (p_fault_stat) else $error("fault status wrong");

    property p_init_rej;
        @(posedge clk) disable iff (rst)
        (state_q == DPSM_ST_INIT && wr_par) |=> $stable(param_q);
    endproperty
    a_init_rej: assert property (p_init_rej) else $error("write taken in init");

    property p_rpar_blk;
        @(posedge clk) disable iff (rst)
        (state_q == DPSM_ST_OPEN && wr_rpar) |=> $stable(rparam_q);
    endproperty
    a_rpar_blk: assert property (p_rpar_blk) else $error("restricted write in op");

    property p_ignore;
        @(posedge clk) disable iff (rst)
        (state_q == DPSM_ST_READY && !fault_q && cw_new_q &&
         cw != DPSM_CW_SWITCHON && cw != DPSM_CW_DISABLE) |=> state_q == DPSM_ST_READY;
    endproperty
    a_ignore: assert property (p_ignore) else $error("undefined value acted on");

endmodule

`default_nettype wire

// ==== dpsm_host.sv ====
// host controller model: drives the register port of the power state machine
// assumes one clock; strobes change by non-blocking assignment after a rising edge
`timescale 1ns/1ns
`default_nettype none

module dpsm_host
    import dpsm_pkg::*;
(
    input wire logic clk,
    output dpsm_req_t req,
    input wire logic [15:0] rdata
);
    // idle bus at time zero
    initial req = '0;

    // one-cycle write, data scrambled once the strobe is gone
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
        req.wdata <= ~d;
    endtask

    // one-cycle read, data taken in the single cycle it stands
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // control word write issued by the host
    task automatic ctrl(input logic [15:0] v);
        wr(DPSM_OFF_CTRL, v);
    endtask
endmodule

`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the drive power state machine
// assumes dpsm_host as the register master and the bench as motor and fault source
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import dpsm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fault_in = 1'b0;
    logic stop_done_in = 1'b0;
    logic io_freset_in = 1'b0;
    dpsm_req_t req;
    dpsm_pwr_t pwr;
    logic [15:0] rdata;
    logic [15:0] status_word;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] modes [6] = '{8'h00, 8'h01, 8'h02, 8'h12, 8'h05, 8'h06};

    // ----------------------------------------------------------------
    // clock, parts and hang guard
    // ----------------------------------------------------------------
    always #5 clk = ~clk;

    dpsm_top i_dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .fault_in(fault_in),
        .stop_done_in(stop_done_in), .io_freset_in(io_freset_in), .pwr(pwr),
        .status_word(status_word));
    dpsm_host i_host (.clk(clk), .req(req), .rdata(rdata));

    // cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // control write, then status once it has landed
    task automatic cmd(input logic [15:0] v, input logic [15:0] st);
        i_host.ctrl(v);
        settle(4);
        check(status_word, st);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_host.rd(a, d);
        check(d, exp);
    endtask

    // climb from switch-on-disabled to operation-enabled
    task automatic up();
        cmd(16'h0006, 16'h0031);
        cmd(16'h0007, 16'h0033);
        cmd(16'h000F, 16'h0037);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        check(status_word, DPSM_SW_INIT);
        i_host.wr(DPSM_OFF_PARAM, 16'h1234);
        rdchk(DPSM_OFF_PARAM, 16'h0000);
        rdchk(DPSM_OFF_WREJ, 16'h0001);
        rdchk(4'hF, 16'h0000);
        settle(100);
        check(status_word, 16'h0070);
        check({12'h000, pwr}, 16'h0000);
        cmd(16'h0003, 16'h0070);
        cmd(16'h0006, 16'h0031);
        cmd(16'h0002, 16'h0031);
        rdchk(DPSM_OFF_STAT, 16'h0031);
        i_host.wr(DPSM_OFF_PARAM, 16'h00A5);
        rdchk(DPSM_OFF_PARAM, 16'h00A5);
        cmd(16'h0007, 16'h0033);
        check({12'h000, pwr}, 16'h0008);
        cmd(16'h000F, 16'h0037);
        check({12'h000, pwr}, 16'h000C);
        i_host.wr(DPSM_OFF_RPARAM, 16'h0055);
        rdchk(DPSM_OFF_RPARAM, 16'h0000);
        rdchk(DPSM_OFF_WREJ, 16'h0002);
        cmd(16'h0007, 16'h0033);
        cmd(16'h0006, 16'h0031);
        cmd(16'h0000, 16'h0070);
        up();
        cmd(16'h0006, 16'h0031);
        cmd(16'h0007, 16'h0033);
        cmd(16'h000F, 16'h0037);
        cmd(16'h0000, 16'h0070);
        // quick stop under every mode
        foreach (modes[i]) begin
            i_host.wr(DPSM_OFF_QSMODE, {8'h00, modes[i]});
            rdchk(DPSM_OFF_QSMODE, {8'h00, modes[i]});
            up();
            cmd(16'h0002, 16'h0050);
            check({15'h0000, pwr.qs_decel}, 16'h0001);
            // only modes 5 and 6 may resume; 18 ends disabled like 0, 1, 2
            if (modes[i] == DPSM_QS_M5 || modes[i] == DPSM_QS_M6) begin
                cmd(16'h000F, 16'h0037);
                cmd(16'h0000, 16'h0070);
            end else begin
                cmd(16'h000F, 16'h0050);
                @(posedge clk) stop_done_in <= 1'b1;
                settle(6);
                check(status_word, 16'h0070);
                check({12'h000, pwr}, 16'h0000);
                @(posedge clk) stop_done_in <= 1'b0;
            end
        end
        // faults from disabled, ready, switched-on and operation
        for (int n = 0; n < 4; n++) begin
            if (n > 0) cmd(16'h0006, 16'h0031);
            if (n > 1) cmd(16'h0007, 16'h0033);
            if (n > 2) cmd(16'h000F, 16'h0037);
            @(posedge clk) fault_in <= 1'b1;
            settle(5);
            check(status_word, 16'h0038);
            check({15'h0000, pwr.err_decel}, 16'h0001);
            @(posedge clk) stop_done_in <= 1'b1;
            settle(6);
            check(status_word, 16'h0038);
            check({12'h000, pwr}, 16'h0000);
            @(posedge clk) fault_in <= 1'b0;
            stop_done_in <= 1'b0;
            settle(4);
            if (n[0] == 1'b0) begin
                cmd(16'h0086, 16'h0031);
            end else begin
                @(posedge clk) io_freset_in <= 1'b1;
                settle(3);
                @(posedge clk) io_freset_in <= 1'b0;
                settle(5);
                check(status_word, 16'h0031);
            end
        end
        // second reset, fault during initialisation
        @(posedge clk) rst <= 1'b1;
        settle(2);
        @(posedge clk) rst <= 1'b0;
        settle(1);
        check(status_word, DPSM_SW_INIT);
        @(posedge clk) fault_in <= 1'b1;
        settle(5);
        check(status_word, 16'h0038);
        print_verdict();
    end
endmodule

`default_nettype wire
